// File: cos_bus_model.sv
`timescale 1ns/1ns
module cos_bus_model
  import cos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic tx_valid,
  input wire logic [1:0] tx_kind,
  input wire logic [10:0] tx_id,
  output logic tx_ready,
  output logic [7:0] hb_cnt,
  output logic [7:0] em_cnt,
  output logic [15:0] hb_gap,
  output logic [15:0] em_gap,
  output logic [10:0] hb_id,
  output logic [10:0] em_id
);
  logic [15:0] cyc;
  logic [15:0] hb_t;
  logic [15:0] em_t;
  // ==========================================================
  // frame engine: mode 0 prompt, 1 half rate, 2 stalled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc <= 16'h0000;
      tx_ready <= 1'h0;
      hb_cnt <= 8'h00;
      em_cnt <= 8'h00;
      hb_t <= 16'h0000;
      em_t <= 16'h0000;
    end
    else
    begin
      cyc <= cyc + 16'h0001;
      tx_ready <= (mode == 2'h0) || (mode == 2'h1 && !tx_ready);
      if (tx_valid && tx_ready && tx_kind == KIND_HB)
      begin
        hb_cnt <= hb_cnt + 8'h01;
        hb_gap <= cyc - hb_t;
        hb_t <= cyc;
        hb_id <= tx_id;
      end
      if (tx_valid && tx_ready && tx_kind == KIND_EMCY)
      begin
        em_cnt <= em_cnt + 8'h01;
        em_gap <= cyc - em_t;
        em_t <= cyc;
        em_id <= tx_id;
      end
    end
  end
endmodule

// File: cos_pair_buf.sv
`timescale 1ns/1ns
module cos_pair_buf
  import cos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cos_stream_if.snk up,
  cos_stream_if.src down
);
  cos_tx_s mem [BUF_DEPTH];
  logic [1:0] count;
  logic wr_ptr;
  logic rd_ptr;
  logic push;
  logic pop;

  // ==========================================================
  // handshake
  assign up.ready = (count != 2'(BUF_DEPTH));
  assign down.valid = (count != 2'h0);
  assign down.data = mem[rd_ptr];
  assign push = clk_en && up.valid && up.ready;
  assign pop = clk_en && down.valid && down.ready;

  // ==========================================================
  // storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
    end
    else if (push)
    begin
      mem[wr_ptr] <= up.data;
      wr_ptr <= ~wr_ptr;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_ptr <= 1'b0;
    else if (pop)
      rd_ptr <= ~rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 2'h0;
    else if (push && !pop)
      count <= count + 2'h1;
    else if (pop && !push)
      count <= count - 2'h1;
  end

  a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    count <= 2'(BUF_DEPTH))
    else $error("pair buffer count out of range");
endmodule

// File: cos_pkg.sv
package cos_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NODE = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;
  localparam logic [7:0] ADDR_HB = 8'h0C;
  localparam logic [7:0] ADDR_TMO = 8'h10;
  localparam logic [7:0] ADDR_EMCY = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_COB_MOSI1 = 8'h20;
  localparam logic [7:0] ADDR_COB_MISO1 = 8'h24;
  localparam logic [7:0] ADDR_COB_MOSI2 = 8'h28;
  localparam logic [7:0] ADDR_COB_MISO2 = 8'h2C;
  localparam logic [7:0] ADDR_MAP_BASE = 8'h80;
  // ==========================================================
  // field positions
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_SETUP_BIT = 1;
  localparam int NODE_SLAVE_LSB = 8;
  localparam int STAT_FAULT_BIT = 8;
  // ==========================================================
  // values after reset
  localparam logic [1:0] MASTER_ID_RST = 2'h0;
  localparam logic [4:0] SLAVE_ID_RST = 5'h01;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [5:0] HB_RST = 6'h19;
  localparam logic [5:0] TMO_RST = 6'h00;
  localparam logic [5:0] EMCY_RST = 6'h04;
  // ==========================================================
  // setting limits, in 4 ms ticks
  localparam logic [5:0] PERIOD_MIN = 6'h04;
  localparam logic [5:0] PERIOD_MAX = 6'h32;
  localparam logic [5:0] GAP_SAT = 6'h3F;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 4;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 17;
  localparam int KBPS_125 = 125;
  localparam int KBPS_250 = 250;
  localparam int KBPS_500 = 500;
  localparam logic [7:0] BT_125 = 8'(CLK_HZ / (KBPS_125 * 1000));
  localparam logic [7:0] BT_250 = 8'(CLK_HZ / (KBPS_250 * 1000));
  localparam logic [7:0] BT_500 = 8'(CLK_HZ / (KBPS_500 * 1000));
  // ==========================================================
  // identifier function codes and network codes
  localparam logic [3:0] FN_EMCY = 4'h1;
  localparam logic [3:0] FN_MISO1 = 4'h3;
  localparam logic [3:0] FN_MOSI1 = 4'h4;
  localparam logic [3:0] FN_MISO2 = 4'h5;
  localparam logic [3:0] FN_MOSI2 = 4'h6;
  localparam logic [3:0] FN_HB = 4'hE;
  localparam logic [6:0] NMT_CODE_INIT = 7'h00;
  localparam logic [6:0] NMT_CODE_STOP = 7'h04;
  localparam logic [6:0] NMT_CODE_OPER = 7'h05;
  localparam logic [6:0] NMT_CODE_PREOP = 7'h7F;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_PREOP = 8'h80;
  localparam logic [7:0] CMD_RESET = 8'h81;
  localparam logic [7:0] CMD_RESET_COMM = 8'h82;
  localparam logic [1:0] KIND_HB = 2'h1;
  localparam logic [1:0] KIND_EMCY = 2'h2;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOP} cos_nmt_e;
  typedef struct packed {
    logic [1:0] kind;
    logic [10:0] id;
  } cos_tx_s;
endpackage

// File: cos_stream_if.sv
`timescale 1ns/1ns
interface cos_stream_if;
  import cos_pkg::*;
  logic valid;
  logic ready;
  cos_tx_s data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: cos_supervisor.sv
// Overview of operation
// - A two-bit master node id selects the identifier of messages taken from the master.
// - A five-bit slave node id forms the upper seven bits of every outgoing identifier.
// - The rate code gives 125, 250 or 500 kbps as a bit time in clock cycles.
// - Heartbeats go out every 4 to 50 ticks, that is 16 to 200 ms.
// - After a process-data send while operational, a missing master reply within the period raises a fault.
// - Either master-to-slave process-data message restarts the reply timer.
// - A reply period of zero never raises the reply fault.
// - Emergency messages keep a programmable least spacing of 16 to 200 ms.
// - With hold-off set at power-up the node stays in initialization.
// - The network state reads 0 init, 4 stopped, 5 operational, 127 pre-operational.
// - Each of the four process-data messages has a readable identifier.
// - Each process-data message keeps eight 32-bit byte mapping entries.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module cos_supervisor
  import cos_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic HOLD_OFF_AT_POWERUP = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mosi1_rx,
  input wire logic mosi2_rx,
  input wire logic miso_sent,
  input wire logic fault_event,
  input wire logic nmt_cmd_valid,
  input wire logic [7:0] nmt_cmd,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [1:0] tx_kind,
  output logic [10:0] tx_id,
  output logic [6:0] network_mgmt_state,
  output logic reply_timeout_fault,
  output logic [7:0] bit_time_cycles
);
  logic hold_off_network_init;
  logic [1:0] master_node_id;
  logic [4:0] slave_node_id;
  logic [1:0] bit_rate;
  logic [5:0] hb_period;
  logic [5:0] reply_timeout_period;
  logic [5:0] emergency_min_interval;
  logic [31:0] map_mem [32];
  cos_nmt_e nmt;
  logic boot;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [5:0] hb_cnt;
  logic hb_pend;
  logic [5:0] tmo_cnt;
  logic tmo_armed;
  logic tmo_expire;
  logic [5:0] emcy_gap;
  logic emcy_pend;
  logic emcy_req;
  logic push;
  logic wr_ce;
  logic setup_go;
  logic fault_clr;
  logic [10:0] cob_mosi1;
  logic [10:0] cob_mosi2;
  logic [10:0] cob_miso1;
  logic [10:0] cob_miso2;
  logic [31:0] next_rdata;

  cos_stream_if req_if ();
  cos_stream_if out_if ();

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  function automatic logic [5:0] clamp(input logic [5:0] v, input logic [5:0] lo);
    logic [5:0] r;
    r = v;
    if (r < lo)
      r = lo;
    if (r > PERIOD_MAX)
      r = PERIOD_MAX;
    return r;
  endfunction

  // ==========================================================
  // register writes
  assign wr_ce = clk_en && reg_wr;
  assign setup_go = wr_ce && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_SETUP_BIT];
  assign fault_clr = wr_ce && (reg_addr == ADDR_STAT) && reg_wdata[STAT_FAULT_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_off_network_init <= HOLD_OFF_AT_POWERUP;
      master_node_id <= MASTER_ID_RST;
      slave_node_id <= SLAVE_ID_RST;
      bit_rate <= RATE_RST;
      hb_period <= HB_RST;
      reply_timeout_period <= TMO_RST;
      emergency_min_interval <= EMCY_RST;
    end
    else if (wr_ce)
    begin
      unique case (reg_addr)
        ADDR_CTRL: hold_off_network_init <= reg_wdata[CTRL_HOLD_BIT];
        ADDR_NODE:
        begin
          master_node_id <= reg_wdata[1:0];
          slave_node_id <= reg_wdata[NODE_SLAVE_LSB +: 5];
        end
        ADDR_RATE: bit_rate <= reg_wdata[1:0];
        ADDR_HB: hb_period <= clamp(reg_wdata[5:0], PERIOD_MIN);
        ADDR_TMO: reply_timeout_period <= clamp(reg_wdata[5:0], 6'h00);
        ADDR_EMCY: emergency_min_interval <= clamp(reg_wdata[5:0], PERIOD_MIN);
        default: ;
      endcase
    end
  end

  // mapping entries, four messages by eight bytes
  always_ff @(posedge clk)
  begin
    if (wr_ce && reg_addr[7])
      map_mem[reg_addr[6:2]] <= reg_wdata;
  end

  // ==========================================================
  // identifiers and bit time
  assign cob_mosi1 = {5'h00, master_node_id, FN_MOSI1};
  assign cob_mosi2 = {5'h00, master_node_id, FN_MOSI2};
  assign cob_miso1 = {2'h0, slave_node_id, FN_MISO1};
  assign cob_miso2 = {2'h0, slave_node_id, FN_MISO2};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bit_time_cycles <= BT_125;
    else if (clk_en)
    begin
      unique case (bit_rate)
        2'h1: bit_time_cycles <= BT_250;
        2'h2: bit_time_cycles <= BT_500;
        default: bit_time_cycles <= BT_125;
      endcase
    end
  end

  // ==========================================================
  // register reads
  always_comb
  begin
    next_rdata = 32'h0;
    if (reg_addr[7])
      next_rdata = map_mem[reg_addr[6:2]];
    else
    begin
      unique case (reg_addr)
        ADDR_CTRL: next_rdata[CTRL_HOLD_BIT] = hold_off_network_init;
        ADDR_NODE: next_rdata = {19'h0, slave_node_id, 6'h00, master_node_id};
        ADDR_RATE: next_rdata = {30'h0, bit_rate};
        ADDR_HB: next_rdata = {26'h0, hb_period};
        ADDR_TMO: next_rdata = {26'h0, reply_timeout_period};
        ADDR_EMCY: next_rdata = {26'h0, emergency_min_interval};
        ADDR_STAT: next_rdata = {23'h0, reply_timeout_fault, 1'b0, network_mgmt_state};
        ADDR_COB_MOSI1: next_rdata = {21'h0, cob_mosi1};
        ADDR_COB_MISO1: next_rdata = {21'h0, cob_miso1};
        ADDR_COB_MOSI2: next_rdata = {21'h0, cob_mosi2};
        ADDR_COB_MISO2: next_rdata = {21'h0, cob_miso2};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (clk_en)
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
  end

  // ==========================================================
  // network management state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmt <= NMT_INIT;
      boot <= 1'b1;
    end
    else if (clk_en)
    begin
      boot <= 1'b0;
      unique case (nmt)
        NMT_INIT:
          if (!hold_off_network_init && (boot || setup_go))
            nmt <= NMT_PREOP;
        NMT_PREOP, NMT_OPER, NMT_STOP:
          if (nmt_cmd_valid)
          begin
            unique case (nmt_cmd)
              CMD_START: nmt <= NMT_OPER;
              CMD_STOP: nmt <= NMT_STOP;
              CMD_PREOP: nmt <= NMT_PREOP;
              CMD_RESET, CMD_RESET_COMM:
              begin
                nmt <= NMT_INIT;
                boot <= 1'b1;
              end
              default: ;
            endcase
          end
      endcase
    end
  end

  always_comb
  begin
    unique case (nmt)
      NMT_INIT: network_mgmt_state = NMT_CODE_INIT;
      NMT_PREOP: network_mgmt_state = NMT_CODE_PREOP;
      NMT_OPER: network_mgmt_state = NMT_CODE_OPER;
      NMT_STOP: network_mgmt_state = NMT_CODE_STOP;
    endcase
  end

  // ==========================================================
  // 4 ms tick
  assign tick = clk_en && (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else if (clk_en)
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  // ==========================================================
  // heartbeat
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hb_cnt <= 6'h00;
      hb_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      if (nmt == NMT_INIT)
      begin
        hb_cnt <= 6'h00;
        hb_pend <= 1'b0;
      end
      else if (tick && hb_cnt >= hb_period - 6'h01)
      begin
        hb_cnt <= 6'h00;
        hb_pend <= 1'b1;
      end
      else
      begin
        if (tick)
          hb_cnt <= hb_cnt + 6'h01;
        if (push && !emcy_req)
          hb_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // reply timeout
  // one full period past the last restart, never early
  assign tmo_expire = nmt == NMT_OPER && tmo_armed && tick && !miso_sent && !mosi1_rx
    && !mosi2_rx && reply_timeout_period != 6'h00 && tmo_cnt == reply_timeout_period;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmo_cnt <= 6'h00;
      tmo_armed <= 1'b0;
    end
    else if (clk_en)
    begin
      if (nmt != NMT_OPER)
        tmo_armed <= 1'b0;
      else if (miso_sent || (tmo_armed && (mosi1_rx || mosi2_rx)))
      begin
        tmo_armed <= 1'b1;
        tmo_cnt <= 6'h00;
      end
      else if (tmo_armed && tick)
      begin
        if (tmo_expire)
          tmo_armed <= 1'b0;
        tmo_cnt <= tmo_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reply_timeout_fault <= 1'b0;
    else if (clk_en)
    begin
      if (tmo_expire)
        reply_timeout_fault <= 1'b1;
      else if (fault_clr)
        reply_timeout_fault <= 1'b0;
    end
  end

  // ==========================================================
  // emergency pacing
  // strictly past the spacing, so a free-running tick never shortens it
  assign emcy_req = emcy_pend && (emcy_gap > emergency_min_interval)
    && (nmt == NMT_PREOP || nmt == NMT_OPER);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emcy_gap <= GAP_SAT;
      emcy_pend <= 1'b0;
    end
    else if (clk_en)
    begin
      if (fault_event || tmo_expire)
        emcy_pend <= 1'b1;
      else if (push && emcy_req)
        emcy_pend <= 1'b0;
      if (push && emcy_req)
        emcy_gap <= 6'h00;
      else if (tick && emcy_gap != GAP_SAT)
        emcy_gap <= emcy_gap + 6'h01;
    end
  end

  // ==========================================================
  // transmit requests through the two-entry buffer
  assign req_if.valid = emcy_req || hb_pend;
  assign req_if.data.kind = emcy_req ? KIND_EMCY : KIND_HB;
  assign req_if.data.id = {2'h0, slave_node_id, emcy_req ? FN_EMCY : FN_HB};
  assign push = clk_en && req_if.valid && req_if.ready;

  cos_pair_buf u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .up(req_if.snk),
    .down(out_if.src)
  );

  assign tx_valid = out_if.valid;
  assign tx_kind = out_if.data.kind;
  assign tx_id = out_if.data.id;
  assign out_if.ready = tx_ready;

  // ==========================================================
  // checks
  a_mosi_id_field: assert property (cob_mosi1[5:4] == master_node_id)
    else $error("mosi identifier ignores master id");
  a_tx_id_upper: assert property (push |-> req_if.data.id[10:4] == {2'h0, slave_node_id})
    else $error("outgoing identifier lacks slave id");
  a_bit_rate_map: assert property (clk_en && bit_rate == 2'h2 |=> bit_time_cycles == 8'h28)
    else $error("500 kbps bit time wrong");
  a_hb_period: assert property ($rose(hb_pend) |-> $past(tick && hb_cnt == hb_period - 6'h01))
    else $error("heartbeat not on period");
  a_timeout_fire: assert property ($rose(reply_timeout_fault)
    |-> $past(tmo_armed && tick && tmo_cnt == reply_timeout_period))
    else $error("reply fault without expiry");
  a_rx_restart: assert property (clk_en && tmo_armed && nmt == NMT_OPER
    && (mosi1_rx || mosi2_rx) |=> tmo_cnt == 6'h00 && !$rose(reply_timeout_fault))
    else $error("reply did not restart timer");
  a_zero_disable: assert property ($rose(reply_timeout_fault)
    |-> $past(reply_timeout_period) != 6'h00)
    else $error("fault with zero period");
  a_emcy_spacing: assert property (push && emcy_req
    |-> emcy_gap > emergency_min_interval && emergency_min_interval >= PERIOD_MIN)
    else $error("emergency too soon");
  a_hold_off_init: assert property (nmt == NMT_INIT && hold_off_network_init
    |=> nmt == NMT_INIT)
    else $error("left init while held off");
  a_nmt_codes: assert property (network_mgmt_state inside {7'h00, 7'h04, 7'h05, 7'h7F})
    else $error("bad network state code");
  a_tick_idle: assert property (tick |=> !tick [*2])
    else $error("ticks too close");
  a_idle_unarmed: assert property ($past(nmt) != NMT_OPER |-> !tmo_armed)
    else $error("reply timer armed outside operational");

  c_heartbeat: cover property (push && !emcy_req);
  c_emergency: cover property (push && emcy_req);
  c_timeout: cover property ($rose(reply_timeout_fault));
  c_setup_after_hold: cover property (nmt == NMT_INIT && setup_go ##1 nmt == NMT_PREOP);
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import cos_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cos_row_s;
  logic clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0] ev;
  logic nmt_cmd_valid;
  logic [7:0] nmt_cmd;
  logic tx_valid;
  logic tx_ready;
  logic [1:0] tx_kind;
  logic [10:0] tx_id;
  logic [6:0] network_mgmt_state;
  logic reply_timeout_fault;
  logic [7:0] bit_time_cycles;
  logic [1:0] mode;
  logic [7:0] hb_cnt;
  logic [7:0] em_cnt;
  logic [15:0] hb_gap;
  logic [15:0] em_gap;
  logic [10:0] hb_id;
  logic [10:0] em_id;
  logic [31:0] v;
  logic [7:0] e0;
  logic [7:0] h0;
  int mismatches;
  int check_count;
  int cycles;
  cos_row_s rows [12] = '{
    '{ADDR_NODE, 32'h00000A02, 32'h00000A02}, '{ADDR_HB, 32'h2, 32'h4},
    '{ADDR_HB, 32'h3C, 32'h32}, '{ADDR_TMO, 32'h3F, 32'h32},
    '{ADDR_EMCY, 32'h1, 32'h4}, '{ADDR_COB_MOSI1, 32'h0, 32'h24},
    '{ADDR_COB_MISO1, 32'h0, 32'hA3}, '{ADDR_COB_MOSI2, 32'h0, 32'h26},
    '{ADDR_COB_MISO2, 32'hFFFF, 32'hA5}, '{8'hA4, 32'hDEADBEEF, 32'hDEADBEEF},
    '{8'hFC, 32'h12345678, 32'h12345678}, '{8'h40, 32'hFFFFFFFF, 32'h0}};
  logic [7:0] bt [4] = '{8'hA0, 8'h50, 8'h28, 8'hA0};
  logic [7:0] cmd [4] = '{CMD_START, CMD_STOP, CMD_PREOP, CMD_START};
  logic [6:0] st [4] = '{7'h05, 7'h04, 7'h7F, 7'h05};

  cos_supervisor #(.TICK_CYCLES(10), .HOLD_OFF_AT_POWERUP(1'h1)) cos_supervisor_i (
    .clk(clk), .rst_n(rst_n), .clk_en(1'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mosi1_rx(ev[0]),
    .mosi2_rx(ev[1]), .miso_sent(ev[2]), .fault_event(ev[3]),
    .nmt_cmd_valid(nmt_cmd_valid), .nmt_cmd(nmt_cmd), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_kind(tx_kind), .tx_id(tx_id),
    .network_mgmt_state(network_mgmt_state), .reply_timeout_fault(reply_timeout_fault),
    .bit_time_cycles(bit_time_cycles));
  cos_bus_model cos_bus_model_i (.clk(clk), .rst_n(rst_n), .mode(mode),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_id(tx_id), .tx_ready(tx_ready),
    .hb_cnt(hb_cnt), .em_cnt(em_cnt), .hb_gap(hb_gap), .em_gap(em_gap),
    .hb_id(hb_id), .em_id(em_id));

  // ==========================================================
  // clock, timeout and shared tasks
  always #25 clk = !clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  task automatic nmt(input logic [7:0] c);
    @(posedge clk);
    nmt_cmd <= c;
    nmt_cmd_valid <= 1'h1;
    @(posedge clk);
    nmt_cmd_valid <= 1'h0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    clk = 1'h0;
    rst_n = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    ev = 4'h0;
    nmt_cmd_valid = 1'h0;
    nmt_cmd = 8'h00;
    mode = 2'h0;
    idle(5);
    #1 chk("bit time in reset", 32'(bit_time_cycles), 32'hA0);
    rst_n = 1'h1;
    idle(10);
    #1 chk("held state", 32'(network_mgmt_state), 32'h0);
    $display("done: reset");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("register", v, rows[i].e);
    end
    @(posedge clk);
    #1 chk("rdata after", reg_rdata, 32'h0);
    $display("done: register table");
    wr(ADDR_HB, 32'h4);
    idle(100);
    chk("no heartbeat held", 32'(hb_cnt), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_RATE, 32'(i));
      idle(2);
      chk("bit time", 32'(bit_time_cycles), 32'(bt[i]));
    end
    $display("done: rates");
    wr(ADDR_CTRL, 32'h3);
    idle(3);
    chk("setup blocked", 32'(network_mgmt_state), 32'h0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    idle(3);
    rd(ADDR_STAT);
    chk("status", v, 32'h7F);
    for (int i = 0; i < 4; i++)
    begin
      nmt(cmd[i]);
      idle(2);
      chk("state", 32'(network_mgmt_state), 32'(st[i]));
    end
    $display("done: network start");
    idle(120);
    chk("heartbeat gap", 32'(hb_gap), 32'd40);
    chk("heartbeat id", 32'(hb_id), 32'h0AE);
    $display("done: heartbeat");
    wr(ADDR_TMO, 32'h0);
    pulse(4'h4);
    idle(100);
    chk("fault off", 32'(reply_timeout_fault), 32'h0);
    wr(ADDR_TMO, 32'h4);
    pulse(4'h4);
    idle(25);
    pulse(4'h1);
    idle(25);
    pulse(4'h2);
    idle(25);
    chk("fault restarted", 32'(reply_timeout_fault), 32'h0);
    idle(40);
    chk("fault", 32'(reply_timeout_fault), 32'h1);
    chk("emergency id", 32'(em_id), 32'h0A1);
    wr(ADDR_STAT, 32'h100);
    idle(2);
    chk("fault cleared", 32'(reply_timeout_fault), 32'h0);
    nmt(CMD_STOP);
    pulse(4'h4);
    idle(80);
    chk("fault stopped", 32'(reply_timeout_fault), 32'h0);
    nmt(CMD_START);
    $display("done: reply timeout");
    idle(60);
    e0 = em_cnt;
    pulse(4'h8);
    idle(3);
    pulse(4'h8);
    idle(100);
    chk("emergency count", 32'(em_cnt), 32'(e0 + 8'h02));
    chk("emergency gap", 32'(em_gap >= 16'd40 && em_gap <= 16'd55), 32'h1);
    mode <= 2'h2;
    idle(3);
    pulse(4'h8);
    idle(150);
    chk("stalled valid", 32'(tx_valid), 32'h1);
    e0 = em_cnt;
    h0 = hb_cnt;
    mode <= 2'h1;
    idle(20);
    chk("emergency kept", 32'(em_cnt), 32'(e0 + 8'h01));
    chk("heartbeat kept", 32'(hb_cnt > h0), 32'h1);
    $display("done: spacing and stall");
    nmt(CMD_RESET);
    #1 chk("state on reset command", 32'(network_mgmt_state), 32'h0);
    idle(1);
    #1 chk("state after reset command", 32'(network_mgmt_state), 32'h7F);
    $display("done: reset command");
    rst_n = 1'h0;
    idle(3);
    #1 chk("valid in reset", 32'(tx_valid), 32'h0);
    chk("state in reset", 32'(network_mgmt_state), 32'h0);
    rst_n = 1'h1;
    idle(10);
    chk("held after reset", 32'(network_mgmt_state), 32'h0);
    rd(ADDR_HB);
    chk("period after reset", v, 32'(HB_RST));
    $display("done: second reset");
    give_verdict();
  end
endmodule
